// File: gstc_consts.vh
// Purpose: Shared constants for the gated sixteen-bit timer/counter
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef GSTC_CONSTS_VH
`define GSTC_CONSTS_VH

// ------------------------------------------------------------
// Clock source field codes
// ------------------------------------------------------------
`define GSTC_CS_INSTR 2'h0
`define GSTC_CS_SYS 2'h1
`define GSTC_CS_EXT 2'h2
`define GSTC_CS_CAP 2'h3

// ------------------------------------------------------------
// Gate source field codes
// ------------------------------------------------------------
`define GSTC_GS_PIN 2'h0
`define GSTC_GS_TIMER_ZERO_COUNT 2'h1
`define GSTC_GS_TIMER_TWO_COUNT 2'h2
`define GSTC_GS_WDOG 2'h3

// ------------------------------------------------------------
// Count limit, reset values, instruction clock divide
// ------------------------------------------------------------
`define GSTC_COUNT_RESET 16'h0000
`define GSTC_COUNT_MAX 16'hffff
`define GSTC_BYTE_ZERO 8'h00
`define GSTC_PRE_RESET 3'h0
`define GSTC_INSTR_DIV_LAST 2'h3

`endif

// File: gstc_sync2.v
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is asynchronous to ref_clk_in
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none

module gstc_sync2 (
	// Clock and reset
	input wire ref_clk_in,
	input wire reset_in,
	// Level in and out
	input wire async_in,
	output reg sync_out
);

	reg stage_one;

	// Two stage capture
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			stage_one <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule
`default_nettype wire

// File: gstc_edge_det.v
// Purpose: Rising and falling edge detector
// Assumes: Input already in the ref_clk_in domain
// Notes: One-cycle pulses
`timescale 1ns/100ps
`default_nettype none

module gstc_edge_det (
	// Clock and reset
	input wire ref_clk_in,
	input wire reset_in,
	// Level and edges
	input wire level_in,
	output wire rise_out,
	output wire fall_out
);

	reg level_d;

	// Delay by one cycle
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			level_d <= 1'b0;
		end else begin
			level_d <= level_in;
		end
	end

	// Edge pulses
	assign rise_out = level_in & ~level_d;
	assign fall_out = ~level_in & level_d;

endmodule
`default_nettype wire

// File: gstc_timer.v
// Purpose: Gated sixteen-bit timer/counter with prescaler and gate logic
// Assumes: One clock ref_clk_in at 40 MHz; all slower rates are enables
// Notes: Asynchronous mode is modelled by counting the raw synchronised
//        edge without the extra falling-edge arming step
//
// Functional notes
// R1: 16-bit count, byte writes replace live bytes
// R2: Run off stops; gate enable selects gating
// R3: Source field picks sys, instr, cap, external
// R4: Internal source counts prescaled instruction cycles
// R5: External source counts rising input edges
// R6: Falling edge needed before first counted rise
// R7: Prescaler divides by 1, 2, 4, 8
// R8: Prescaler hidden; count writes clear it
// R9: Oscillator enable starts crystal, runs in sleep
// R10: No-sync keeps counting in sleep, wakes
// R11: Async reads return valid count value
// R12: Software stops counter before async writes
// R13: Active gate counts, inactive gate holds
// R14: Polarity bit chooses active gate level
// R15: Gate source field picks pin, t0, t2, watchdog
// R16: Timer0 wrap gives gate pulse
// R17: Timer2 period reset gives gate pulse
// R18: Watchdog gate forces watchdog on
// R19: Gate-only watchdog gives no reset, wake
// R20: Watchdog rate bits keep choosing gate interval
// R21: Software uses toggle mode with watchdog gate
// R22: Sync/async switch may drop or add one
// R23: Wrap to zero sets overflow flag
// R24: Toggle flip-flop on gate; cleared when off
// R25: Gate value falling edge sets gate event flag
// R26: Single-pulse go arms, self-clears on trailing edge
// R27: External input passes two-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "gstc_consts.vh"

module gstc_timer #(
	parameter COUNT_WIDTH = 16
) (
	// Clock and reset
	input wire ref_clk_in,
	input wire reset_in,
	// Control bits
	input wire timer_run_bit_in,
	input wire gate_enable_bit_in,
	input wire [1:0] clock_source_field_in,
	input wire crystal_osc_enable_in,
	input wire [1:0] prescale_field_in,
	input wire no_sync_bit_in,
	input wire gate_polarity_bit_in,
	input wire [1:0] gate_source_field_in,
	input wire gate_toggle_enable_in,
	input wire gate_single_pulse_enable_in,
	input wire single_pulse_go_set_in,
	input wire sleep_in,
	input wire watchdog_config_enable_in,
	// Count byte writes and reads
	input wire count_high_write_in,
	input wire count_low_write_in,
	input wire [7:0] write_data_in,
	output reg [7:0] count_high_byte_out,
	output reg [7:0] count_low_byte_out,
	// Pins, already crystal-buffered outside
	input wire external_count_pin_in,
	input wire crystal_clock_in,
	input wire cap_osc_in,
	input wire gate_input_pin_in,
	// Internal gate sources
	input wire timer_zero_wrap_in,
	input wire timer_two_match_reset_in,
	input wire watchdog_overflow_in,
	// Status and side outputs
	output reg single_pulse_go_bit_out,
	output reg gate_current_value_out,
	output reg overflow_flag_set_out,
	output reg gate_event_flag_set_out,
	output reg wake_request_out,
	output reg crystal_osc_run_out,
	output reg watchdog_gate_force_on_out,
	output reg watchdog_reset_allow_out
);

	// ------------------------------------------------------------
	// Instruction clock enable and input synchronisers
	// ------------------------------------------------------------
	reg [1:0] instr_div;
	wire instr_tick;
	wire ext_pin_s;
	wire xtal_s;
	wire cap_s;
	wire gate_pin_s;
	wire ext_sel;
	wire ext_rise;
	wire ext_fall;

	// Divide by four for the instruction clock
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			instr_div <= 2'h0;
		end else begin
			instr_div <= instr_div + 2'h1;
		end
	end
	assign instr_tick = (instr_div == `GSTC_INSTR_DIV_LAST);

	// Pin synchronisers
	gstc_sync2 u_sync_ext (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in(external_count_pin_in),
		.sync_out(ext_pin_s)
	); // R27
	gstc_sync2 u_sync_xtal (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in(crystal_clock_in),
		.sync_out(xtal_s)
	); // R27
	gstc_sync2 u_sync_cap (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in(cap_osc_in),
		.sync_out(cap_s)
	);
	gstc_sync2 u_sync_gate (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in(gate_input_pin_in),
		.sync_out(gate_pin_s)
	);

	// External level selection: pin or crystal, or cap oscillator
	assign ext_sel = (clock_source_field_in == `GSTC_CS_CAP) ? cap_s :
		(crystal_osc_enable_in ? xtal_s : ext_pin_s); // R3 R5

	gstc_edge_det u_edge_ext (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.level_in(ext_sel),
		.rise_out(ext_rise),
		.fall_out(ext_fall)
	);

	// ------------------------------------------------------------
	// Clock source select and prescaler
	// ------------------------------------------------------------
	reg src_tick;
	reg armed;
	reg [2:0] pre_cnt;
	reg pre_tick;
	wire is_external;
	wire count_write;
	wire run_ok;

	assign is_external = clock_source_field_in[1];
	assign count_write = count_high_write_in | count_low_write_in;
	// Sleep stops all but the unsynchronised external and cap oscillator sources
	assign run_ok = timer_run_bit_in & (~sleep_in | (is_external & no_sync_bit_in)); // R10

	// Pick the raw increment event for the chosen source
	always @* begin
		case (clock_source_field_in)
			`GSTC_CS_SYS: src_tick = 1'b1; // R3
			`GSTC_CS_INSTR: src_tick = instr_tick; // R4
			default: src_tick = ext_rise & (armed | no_sync_bit_in); // R5 R6 R22
		endcase
	end

	// Falling edge arms counting after enable, write or disable
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			armed <= 1'b0;
		end else if (count_write || !timer_run_bit_in) begin
			armed <= 1'b0; // R6
		end else if (ext_fall) begin
			armed <= 1'b1; // R6
		end
	end

	// Prescale counter, hidden from software, cleared on count writes
	always @(posedge ref_clk_in) begin
		if (reset_in || count_write) begin
			pre_cnt <= `GSTC_PRE_RESET; // R8
		end else if (src_tick && run_ok) begin
			pre_cnt <= pre_cnt + 3'h1;
		end
	end

	// Prescaled tick at 1, 2, 4 or 8
	always @* begin
		case (prescale_field_in)
			2'h0: pre_tick = src_tick; // R7
			2'h1: pre_tick = src_tick & pre_cnt[0]; // R7
			2'h2: pre_tick = src_tick & (&pre_cnt[1:0]); // R7
			default: pre_tick = src_tick & (&pre_cnt); // R7
		endcase
	end

	// ------------------------------------------------------------
	// Gate source, polarity, toggle and single pulse
	// ------------------------------------------------------------
	reg gate_src;
	reg toggle_q;
	reg gate_src_d;
	reg next_gate_value;
	wire gate_after_pol;
	wire gate_rise;

	// Gate source mux
	always @* begin
		case (gate_source_field_in)
			`GSTC_GS_PIN: gate_src = gate_pin_s; // R15
			`GSTC_GS_TIMER_ZERO_COUNT: gate_src = timer_zero_wrap_in; // R15 R16
			`GSTC_GS_TIMER_TWO_COUNT: gate_src = timer_two_match_reset_in; // R15 R17
			default: gate_src = watchdog_overflow_in; // R15
		endcase
	end

	// Polarity: clear means active low
	assign gate_after_pol = gate_polarity_bit_in ? gate_src : ~gate_src; // R14
	assign gate_rise = gate_after_pol & ~gate_src_d;

	// Toggle flip-flop, held clear while toggle mode is off
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			gate_src_d <= 1'b0;
			toggle_q <= 1'b0;
		end else begin
			gate_src_d <= gate_after_pol;
			if (!gate_toggle_enable_in) begin
				toggle_q <= 1'b0; // R24
			end else if (gate_rise) begin
				toggle_q <= ~toggle_q; // R24
			end
		end
	end

	// Gate value after toggle and single-pulse qualification
	always @* begin
		next_gate_value = gate_toggle_enable_in ? toggle_q : gate_after_pol;
		if (gate_single_pulse_enable_in) begin
			next_gate_value = next_gate_value & single_pulse_go_bit_out; // R26
		end
	end

	// Go bit: software set, hardware clear on trailing gate edge
	always @(posedge ref_clk_in) begin
		if (reset_in || !gate_single_pulse_enable_in) begin
			single_pulse_go_bit_out <= 1'b0;
		end else if (single_pulse_go_set_in) begin
			single_pulse_go_bit_out <= 1'b1; // R26
		end else if (gate_current_value_out && !next_gate_value) begin
			single_pulse_go_bit_out <= 1'b0; // R26
		end
	end

	// Gate value register and gate event flag pulse
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			gate_current_value_out <= 1'b0;
			gate_event_flag_set_out <= 1'b0;
		end else begin
			gate_current_value_out <= next_gate_value;
			gate_event_flag_set_out <= gate_current_value_out & ~next_gate_value; // R25
		end
	end

	// ------------------------------------------------------------
	// Sixteen-bit counter and overflow
	// ------------------------------------------------------------
	reg [COUNT_WIDTH-1:0] count;
	wire count_enable;
	wire do_inc;

	// Run and gate enable table
	assign count_enable = run_ok & (~gate_enable_bit_in | gate_current_value_out); // R2 R13
	assign do_inc = count_enable & pre_tick;

	// Count update; byte writes take priority over increments
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			count <= `GSTC_COUNT_RESET;
			overflow_flag_set_out <= 1'b0;
		end else begin
			overflow_flag_set_out <= 1'b0;
			if (count_write) begin
				if (count_high_write_in) begin
					count[15:8] <= write_data_in; // R1
				end
				if (count_low_write_in) begin
					count[7:0] <= write_data_in; // R1
				end
			end else if (do_inc) begin
				count <= count + 16'h0001; // R1
				if (count == `GSTC_COUNT_MAX) begin
					overflow_flag_set_out <= 1'b1; // R23
				end
			end
		end
	end

	// Read bytes come from flops in this domain, always coherent
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			count_high_byte_out <= `GSTC_BYTE_ZERO;
			count_low_byte_out <= `GSTC_BYTE_ZERO;
		end else begin
			count_high_byte_out <= count[15:8]; // R11
			count_low_byte_out <= count[7:0]; // R11
		end
	end

	// ------------------------------------------------------------
	// Side outputs: wake, crystal, watchdog control
	// ------------------------------------------------------------
	always @(posedge ref_clk_in) begin
		if (reset_in) begin
			wake_request_out <= 1'b0;
			crystal_osc_run_out <= 1'b0;
			watchdog_gate_force_on_out <= 1'b0;
			watchdog_reset_allow_out <= 1'b0;
		end else begin
			wake_request_out <= sleep_in & do_inc & (count == `GSTC_COUNT_MAX); // R10
			crystal_osc_run_out <= crystal_osc_enable_in; // R9
			watchdog_gate_force_on_out <= gate_enable_bit_in &
				(gate_source_field_in == `GSTC_GS_WDOG); // R18 R20
			watchdog_reset_allow_out <= watchdog_config_enable_in; // R19
		end
	end

endmodule
`default_nettype wire

// File: gstc_timer_properties.sv
// Purpose: Port-level checks for the gated timer/counter
// Assumes: Bound to gstc_timer, one clock domain
// Notes: Byte outputs lag the live count by one cycle
`timescale 1ns/100ps
`default_nettype none
module gstc_timer_properties (
	// Clock, reset and controls
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic timer_run_bit_in,
	input wire logic gate_enable_bit_in,
	input wire logic [1:0] gate_source_field_in,
	input wire logic crystal_osc_enable_in,
	input wire logic watchdog_config_enable_in,
	input wire logic gate_single_pulse_enable_in,
	input wire logic single_pulse_go_set_in,
	input wire logic count_high_write_in,
	input wire logic count_low_write_in,
	input wire logic [7:0] write_data_in,
	// Observed outputs
	input wire logic [7:0] count_high_byte_out,
	input wire logic [7:0] count_low_byte_out,
	input wire logic single_pulse_go_bit_out,
	input wire logic gate_current_value_out,
	input wire logic overflow_flag_set_out,
	input wire logic gate_event_flag_set_out,
	input wire logic crystal_osc_run_out,
	input wire logic watchdog_gate_force_on_out,
	input wire logic watchdog_reset_allow_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	// Byte writes land two cycles later
	chk_low_write: assert property (count_low_write_in |-> ##2
		count_low_byte_out == $past(write_data_in, 2)) else $error("low byte write lost");
	chk_high_write: assert property (count_high_write_in |-> ##2
		count_high_byte_out == $past(write_data_in, 2)) else $error("high byte write lost");
	// Stopped counter holds
	chk_run_off_hold: assert property ((!timer_run_bit_in && !count_high_write_in
		&& !count_low_write_in)[*4] |=> $stable({count_high_byte_out, count_low_byte_out}))
		else $error("count moved while stopped");
	// Wrap flag is a single pulse at zero
	chk_wrap_zero: assert property (overflow_flag_set_out |-> ##[0:2]
		{count_high_byte_out, count_low_byte_out} == 16'h0000) else $error("wrap not at zero");
	chk_wrap_pulse: assert property (overflow_flag_set_out |=> !overflow_flag_set_out)
		else $error("wrap flag too long");
	// Gate event on falling gate value
	chk_gate_event: assert property ($fell(gate_current_value_out) |-> ##[0:1]
		gate_event_flag_set_out) else $error("gate event missed");
	chk_event_pulse: assert property (gate_event_flag_set_out |=> !gate_event_flag_set_out)
		else $error("gate event too long");
	// Watchdog and crystal side controls, go bit clear
	chk_wdog_force: assert property ((gate_enable_bit_in && gate_source_field_in == 2'h3)[*2]
		|-> watchdog_gate_force_on_out) else $error("watchdog not forced on");
	chk_wdog_reset: assert property ((!watchdog_config_enable_in)[*2]
		|-> !watchdog_reset_allow_out) else $error("watchdog reset allowed");
	chk_xtal_run: assert property (crystal_osc_enable_in[*2] |-> crystal_osc_run_out)
		else $error("crystal not running");
	chk_go_clear: assert property ((!gate_single_pulse_enable_in
		&& !single_pulse_go_set_in)[*2] |-> !single_pulse_go_bit_out) else $error("go bit stuck");
endmodule
`default_nettype wire

// File: gstc_far_side.sv
// Purpose: Pin-side model: count pin, crystal and gate pin
// Assumes: Pins rest low when idle
// Notes: Half periods unrelated to the 25 ns clock
`timescale 1ns/100ps
`default_nettype none
module gstc_far_side #(
	parameter int PIN_HALF = 110,
	parameter int XTAL_HALF = 170
) (
	// Controls
	input wire logic clk_en_in,
	input wire logic osc_run_in,
	input wire logic gate_level_in,
	// Pins
	output logic ext_pin_out,
	output logic crystal_out,
	output wire logic gate_pin_out
);
	initial ext_pin_out = 1'b0;
	initial crystal_out = 1'b0;
	// Count pin toggles only while enabled, else rests low
	always #PIN_HALF ext_pin_out = clk_en_in ? ~ext_pin_out : 1'b0;
	// Crystal swings while its oscillator runs and the bench opens a window
	always #XTAL_HALF crystal_out = (osc_run_in && clk_en_in) ? ~crystal_out : 1'b0;
	assign gate_pin_out = gate_level_in;
endmodule
`default_nettype wire

// File: gstc_timer_test.sv
// Purpose: Self-checking bench for the gated timer/counter
// Assumes: Inputs change at the falling edge
// Notes: Counts are compared as deltas over fixed spans or as absolute values after writes
`timescale 1ns/100ps
`default_nettype none
module gstc_timer_test;
	logic ref_clk_in = 0, reset_in = 1, timer_run_bit_in = 0, gate_enable_bit_in = 0;
	logic [1:0] clock_source_field_in = 2'h1, prescale_field_in = 2'h0, gate_source_field_in = 2'h0;
	logic crystal_osc_enable_in = 0, no_sync_bit_in = 0, gate_polarity_bit_in = 0, sleep_in = 0;
	logic gate_toggle_enable_in = 0, gate_single_pulse_enable_in = 0, single_pulse_go_set_in = 0;
	logic watchdog_config_enable_in = 0, count_high_write_in = 0, count_low_write_in = 0;
	logic [7:0] write_data_in = 8'h00, count_high_byte_out, count_low_byte_out;
	logic timer_zero_wrap_in = 0, timer_two_match_reset_in = 0, watchdog_overflow_in = 0;
	logic single_pulse_go_bit_out, gate_current_value_out, overflow_flag_set_out;
	logic gate_event_flag_set_out, wake_request_out, crystal_osc_run_out;
	logic watchdog_gate_force_on_out, watchdog_reset_allow_out, pin_run = 0, gate_level = 0;
	wire external_count_pin_in, crystal_clock_in, gate_input_pin_in;
	wire cap_osc_in = external_count_pin_in;
	int bad_count = 0, comparisons = 0, rises = 0;
	gstc_timer u_gstc_timer (.*);
	gstc_far_side u_gstc_far_side (.clk_en_in(pin_run), .osc_run_in(crystal_osc_run_out),
		.gate_level_in(gate_level), .ext_pin_out(external_count_pin_in),
		.crystal_out(crystal_clock_in), .gate_pin_out(gate_input_pin_in));
	always #12.5 ref_clk_in = ~ref_clk_in;
	wire count_src = crystal_osc_enable_in ? crystal_clock_in : external_count_pin_in;
	always @(posedge count_src) rises++;
	// ----
	// Helpers
	// ----
	task stop_test;
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	// Increase of the count over n cycles
	task automatic span(input int n, input logic [15:0] exp, input string what);
		logic [15:0] a;
		a = {count_high_byte_out, count_low_byte_out};
		cyc(n);
		cmp16(what, exp, {count_high_byte_out, count_low_byte_out} - a);
	endtask
	task automatic wr(input logic [15:0] v);
		@(negedge ref_clk_in) count_high_write_in = 1;
		write_data_in = v[15:8];
		@(negedge ref_clk_in) count_high_write_in = 0;
		count_low_write_in = 1;
		write_data_in = v[7:0];
		@(negedge ref_clk_in) count_low_write_in = 0;
	endtask
	task automatic pulse(input int s);
		@(negedge ref_clk_in) timer_zero_wrap_in = (s == 1);
		timer_two_match_reset_in = (s == 2);
		watchdog_overflow_in = (s == 3);
		@(negedge ref_clk_in) {timer_zero_wrap_in, timer_two_match_reset_in, watchdog_overflow_in} = 0;
	endtask
	// ----
	// Scenarios
	// ----
	task t_enable;
		wr(16'ha53c);
		cyc(3);
		cmp16("count write", 16'ha53c, {count_high_byte_out, count_low_byte_out});
		gate_enable_bit_in = 1;
		span(8, 0, "run off gated");
		gate_enable_bit_in = 0;
		span(8, 0, "run off");
		timer_run_bit_in = 1;
		cyc(4);
		span(8, 8, "run on");
	endtask
	task t_rates;
		for (int s = 0; s < 2; s++)
			for (int p = 0; p < 4; p++) begin
				clock_source_field_in = 2'(s);
				prescale_field_in = 2'(p);
				cyc(6);
				span(64, 16'((s ? 64 : 16) >> p), "internal rate");
			end
		wr(16'h1234);
		cyc(8);
		cmp16("prescale clear", 16'h1234, {count_high_byte_out, count_low_byte_out});
	endtask
	task t_ext;
		prescale_field_in = 2'h0;
		for (int k = 0; k < 6; k++) begin
			clock_source_field_in = (k == 1 || k == 3) ? 2'h3 : 2'h2;
			no_sync_bit_in = (k == 2 || k == 3 || k == 5);
			crystal_osc_enable_in = (k >= 4);
			pin_run = 0;
			cyc(12);
			timer_run_bit_in = 0;
			wr(16'h0000);
			timer_run_bit_in = 1;
			cyc(4);
			rises = 0;
			pin_run = 1;
			cyc(120);
			pin_run = 0;
			cyc(12);
			cmp16("edge count", 16'(rises - (no_sync_bit_in ? 0 : 1)),
				{count_high_byte_out, count_low_byte_out});
		end
	endtask
	task t_gate;
		{clock_source_field_in, gate_enable_bit_in, no_sync_bit_in} = 4'h6;
		for (int p = 0; p < 2; p++) begin
			gate_polarity_bit_in = p[0];
			gate_level = ~p[0];
			cyc(6);
			span(16, 0, "gate inactive");
			gate_level = p[0];
			cyc(6);
			span(16, 16, "gate active");
		end
		{gate_toggle_enable_in, watchdog_config_enable_in, crystal_osc_enable_in} = 3'h7;
		for (int s = 1; s < 4; s++) begin
			gate_source_field_in = 2'(s);
			cyc(6);
			span(16, 0, "toggle idle");
			pulse(s);
			cyc(6);
			span(16, 16, "toggle on");
			pulse(s);
			cyc(6);
			span(16, 0, "toggle off");
		end
		cmp16("watchdog side", 16'h0007, {13'h0000, crystal_osc_run_out,
			watchdog_gate_force_on_out, watchdog_reset_allow_out});
		pulse(3);
		cyc(6);
		gate_toggle_enable_in = 0;
		cyc(6);
		gate_toggle_enable_in = 1;
		cyc(6);
		span(16, 0, "toggle cleared");
	endtask
	task t_pulse;
		{gate_source_field_in, gate_toggle_enable_in, gate_level} = 4'h1;
		gate_single_pulse_enable_in = 1;
		cyc(6);
		span(16, 0, "pulse not armed");
		gate_level = 0;
		cyc(6);
		single_pulse_go_set_in = 1;
		cyc(1);
		single_pulse_go_set_in = 0;
		cyc(2);
		cmp16("go bit set", 16'h0001, {15'h0000, single_pulse_go_bit_out});
		span(16, 0, "pulse armed idle");
		gate_level = 1;
		cyc(6);
		span(16, 16, "pulse active");
		gate_level = 0;
		cyc(6);
		cmp16("go bit done", 16'h0000, {15'h0000, single_pulse_go_bit_out});
		gate_level = 1;
		cyc(6);
		span(16, 0, "pulse blocked");
		gate_single_pulse_enable_in = 0;
	endtask
	task t_over;
		int n;
		{gate_enable_bit_in, timer_run_bit_in} = 2'h0;
		wr(16'hfff0);
		timer_run_bit_in = 1;
		for (n = 0; n < 40 && overflow_flag_set_out !== 1'b1; n++)
			cyc(1);
		cmp16("overflow flag", 16'h0001, {15'h0000, overflow_flag_set_out});
		sleep_in = 1;
		cyc(2);
		span(8, 0, "sleep stop");
		{timer_run_bit_in, clock_source_field_in, no_sync_bit_in, crystal_osc_enable_in} = 5'h0a;
		wr(16'hfffe);
		timer_run_bit_in = 1;
		pin_run = 1;
		for (n = 0; n < 80 && wake_request_out !== 1'b1; n++)
			cyc(1);
		pin_run = 0;
		cmp16("sleep wake", 16'h0001, {15'h0000, wake_request_out});
		sleep_in = 0;
	endtask
	initial begin
		cyc(10);
		reset_in = 0;
		cyc(2);
		t_enable;
		t_rates;
		t_ext;
		t_gate;
		t_pulse;
		t_over;
		stop_test;
	end
	initial begin
		#200000;
		bad_count++;
		stop_test;
	end
endmodule
bind gstc_timer gstc_timer_properties u_gstc_timer_properties (.*);
`default_nettype wire
